// [common/smf_pkg.sv]
/*
 * Constants for the system mode and failure controller: register map,
 * field positions, reset values, mode codes and timing counts.
 * Assumes a 125 MHz clock and a plain strobed register port.
 */
// What this block does
// R01 - watchdog failure in normal, stop or init pulls reset low; fail outputs after first or second failure
// R02 - watchdog failure goes to restart or fail-safe by strap and failure-count select
// R03 - overvoltage without reset enable sets flag only; mode and fail outputs unchanged
// R04 - overvoltage with reset enable sets flag, fail outputs, restart or fail-safe by strap
// R05 - stored failure configuration changes only after power-on reset
// R06 - any command in init moves the mode to normal; a soft reset write in init keeps the mode at init
// R07 - missing watchdog trigger in the open window means failure and restart
// R08 - wake events during init are dropped without flag or interrupt
// R09 - host should trigger and configure the watchdog with its first command
// R10 - at power-up suppress undervoltage flag and fail outputs; reset low; the flag is suppressed only while vsLow is also set
// R11 - wake in normal or stop raises interrupt without mode change
// R12 - from init to normal, regulators, transceivers, high-side and fail outputs off
// R13 - from restart, high-side off, transceivers off or wake-capable, fail outputs kept
// R14 - in normal the test bit drives the fail outputs on and off
// R15 - in stop writes set command error except normal mode request, soft reset, status and wake flag clears
// R16 - in stop the supply, wake and fail settings stay frozen
// R17 - entering stop with wake flags still set raises interrupt
// R18 - stop to sleep request sets command error and enters restart
// R19 - measurement select removes the first two wake inputs as wake sources
// R20 - status shows wake input levels; each input enabled individually as source
// R21 - strap sampled through filter during reset delay, latched at reset release
// R22 - no stable strap level stores zero, selecting fail-safe
// R23 - mode field shows current mode and reads normal after restart
// R24 - modes are exclusive states; stop entered only from normal by request
package smf_pkg;
	typedef enum logic [2:0] {
		MODE_NORMAL = 3'h0,
		MODE_SLEEP = 3'h1,
		MODE_STOP = 3'h2,
		MODE_INIT = 3'h4,
		MODE_RESTART = 3'h5,
		MODE_FAILSAFE = 3'h6
	} smf_mode_t;
	localparam logic [3:0] ADDR_MODE = 4'h0;
	localparam logic [3:0] ADDR_SUPPLY = 4'h1;
	localparam logic [3:0] ADDR_WAKE_EN = 4'h2;
	localparam logic [3:0] ADDR_STATUS = 4'h3;
	localparam logic [3:0] ADDR_WAKE_FIRST = 4'h4;
	localparam logic [3:0] ADDR_WAKE_SECOND = 4'h5;
	localparam logic [3:0] ADDR_WAKE_LEVEL = 4'h6;
	localparam int BIT_OV_RST = 3;
	localparam int BIT_FAIL_SEL = 4;
	localparam int BIT_FO_TEST = 5;
	localparam int BIT_MEAS = 6;
	localparam int BIT_SOFT_RST = 7;
	localparam logic [1:0] XCVR_OFF = 2'h0;
	localparam logic [1:0] XCVR_WAKE = 2'h1;
	localparam logic [1:0] XCVR_ON = 2'h2;
	localparam logic [5:0] SUPPLY_RST = 6'h00;
	localparam logic [2:0] WAKE_EN_RST = 3'h0;
	localparam int CLK_NS = 8;
	localparam int RESET_DELAY_NS = 10000;
	localparam int CFG_FILTER_NS = 1000;
	localparam int INT_PULSE_NS = 100;
	localparam int RESET_DELAY_CYC = (RESET_DELAY_NS + CLK_NS - 1) / CLK_NS;
	localparam int CFG_FILTER_CYC = (CFG_FILTER_NS + CLK_NS - 1) / CLK_NS;
	localparam int INT_PULSE_CYC = (INT_PULSE_NS + CLK_NS - 1) / CLK_NS;
endpackage : smf_pkg

// [hdl/smf_controller.sv]
/*
 * Operating-mode and failure controller: mode state machine, failure
 * handling, strap sensing, wake flags, interrupt and fail outputs.
 * Assumes a watchdog that pulses wdFail on the same clock and pins that
 * arrive asynchronously.
 */
`timescale 1ns/100ps
module smf_controller #(
	parameter int RESET_DELAY_CYC = smf_pkg::RESET_DELAY_CYC,
	parameter int CFG_FILTER_CYC = smf_pkg::CFG_FILTER_CYC
) (
	input wire logic clock,
	input wire logic rst_b,
	input wire logic [3:0] addr,
	input wire logic [7:0] wrData,
	input wire logic wrStb,
	input wire logic rdStb,
	output logic [7:0] rdData,
	input wire logic wdFail,
	input wire logic vsLow,
	input wire logic mainUnder,
	input wire logic mainOver,
	input wire logic [2:0] wakeInputs,
	input wire logic busWake,
	input wire logic intPinIn,
	output logic intPinOut,
	output logic intPinOe,
	output logic resetOut_b,
	output logic failOutputs_b,
	output logic secondRegOn,
	output logic thirdRegOn,
	output logic [1:0] xcvrMode,
	output logic highSideOn,
	output logic cyclicOn,
	output smf_pkg::smf_mode_t mode
);
	// ----------------------------------------
	// state
	// ----------------------------------------
	typedef struct packed {
		smf_pkg::smf_mode_t mode;
		logic [7:0] s1;
		logic [7:0] s2;
		logic ovPrev;
		logic powerUp;
		logic [15:0] rdCnt;
		logic [15:0] filtCnt;
		logic intPrev;
		logic cfgStable;
		logic pin_sensed_config;
		logic ovRstEn;
		logic failSel;
		logic foTest;
		logic measSel;
		logic [5:0] supply;
		logic [2:0] wakeEn;
		logic ovFlag;
		logic uvFlag;
		logic cmdErr;
		logic [1:0] wdCnt;
		logic failLatched;
		logic [2:0] wkFirst;
		logic wkSecond;
		logic [3:0] intCnt;
		logic intPinOut;
		logic intPinOe;
		logic resetOut_b;
		logic failOutputs_b;
		logic [7:0] rdData;
	} smf_state_t;

	smf_state_t s;
	smf_state_t next_s;
	logic ovEdge;
	logic active;
	logic [2:0] wkSrc;
	logic wkNew;
	logic [1:0] cntUp;
	smf_pkg::smf_mode_t reqMode;

	// pin order in the synchroniser: vsLow, under, over, int, wake[3], bus
	assign ovEdge = s.s2[2] & ~s.ovPrev;
	assign active = ~s.powerUp & (s.mode == smf_pkg::MODE_NORMAL
		| s.mode == smf_pkg::MODE_STOP | s.mode == smf_pkg::MODE_INIT);
	assign wkSrc = s.s2[6:4] & s.wakeEn & ~{1'b0, {2{s.measSel}}}; // [R19] [R20]
	assign reqMode = smf_pkg::smf_mode_t'(wrData[2:0]);

	always_comb begin
		next_s = s;
		wkNew = 1'b0;
		cntUp = 2'h0;
		next_s.s1 = {busWake, wakeInputs, intPinIn, mainOver, mainUnder, vsLow};
		next_s.s2 = s.s1;
		next_s.ovPrev = s.s2[2];
		if (next_s.intCnt != 4'h0) begin
			next_s.intCnt = s.intCnt - 4'h1;
		end
		// ----------------------------------------
		// reset delay and strap sensing
		// ----------------------------------------
		if (s.powerUp | s.mode == smf_pkg::MODE_RESTART) begin
			next_s.resetOut_b = 1'b0;
			if (s.s2[1]) begin
				next_s.rdCnt = 16'h0000; // [R10]
			end else if (s.rdCnt == 16'(RESET_DELAY_CYC - 1)) begin
				next_s.rdCnt = 16'h0000;
				next_s.resetOut_b = 1'b1;
				if (s.powerUp) begin
					next_s.powerUp = 1'b0;
					next_s.pin_sensed_config = s.cfgStable & s.intPrev; // [R21] [R22] [R05]
				end else begin
					next_s.mode = smf_pkg::MODE_NORMAL; // [R23]
				end
			end else begin
				next_s.rdCnt = s.rdCnt + 16'h0001;
			end
		end
		if (s.powerUp) begin
			next_s.intPrev = s.s2[3];
			if (s.s2[3] != s.intPrev | s.s2[1]) begin
				next_s.filtCnt = 16'h0000; // [R21]
				next_s.cfgStable = 1'b0;
			end else if (s.filtCnt == 16'(CFG_FILTER_CYC - 1)) begin
				next_s.cfgStable = 1'b1;
			end else begin
				next_s.filtCnt = s.filtCnt + 16'h0001;
			end
		end
		// ----------------------------------------
		// register port
		// ----------------------------------------
		if (rdStb) begin
			unique case (addr)
				smf_pkg::ADDR_MODE: next_s.rdData = {1'b0, s.measSel, s.foTest, s.failSel,
					s.ovRstEn, s.mode}; // [R23]
				smf_pkg::ADDR_SUPPLY: next_s.rdData = {2'h0, s.supply};
				smf_pkg::ADDR_WAKE_EN: next_s.rdData = {5'h00, s.wakeEn};
				smf_pkg::ADDR_STATUS: next_s.rdData = {2'h0, s.wdCnt, s.pin_sensed_config, s.cmdErr,
					s.uvFlag, s.ovFlag};
				smf_pkg::ADDR_WAKE_FIRST: next_s.rdData = {5'h00, s.wkFirst};
				smf_pkg::ADDR_WAKE_SECOND: next_s.rdData = {7'h00, s.wkSecond};
				smf_pkg::ADDR_WAKE_LEVEL: next_s.rdData = {4'h0, s.s2[7:4]}; // [R20]
				default: next_s.rdData = 8'h00;
			endcase
		end else begin
			next_s.rdData = 8'h00;
		end
		// commands are not interpreted during restart or power-up
		if ((wrStb | rdStb) & active) begin
			if (s.mode == smf_pkg::MODE_INIT) begin
				next_s.mode = smf_pkg::MODE_NORMAL; // [R06]
			end
			if (wrStb) begin
				if (addr == smf_pkg::ADDR_STATUS) begin
					next_s.ovFlag = s.ovFlag & ~wrData[0];
					next_s.uvFlag = s.uvFlag & ~wrData[1];
					next_s.cmdErr = s.cmdErr & ~wrData[2];
					if (wrData[5:4] != 2'h0) begin
						next_s.wdCnt = 2'h0;
					end
				end else if (addr == smf_pkg::ADDR_WAKE_FIRST) begin
					next_s.wkFirst = s.wkFirst & ~wrData[2:0];
				end else if (addr == smf_pkg::ADDR_WAKE_SECOND) begin
					next_s.wkSecond = s.wkSecond & ~wrData[0];
				end else if (s.mode == smf_pkg::MODE_STOP) begin
					if (addr == smf_pkg::ADDR_MODE & wrData[smf_pkg::BIT_SOFT_RST]) begin
						next_s.mode = smf_pkg::MODE_INIT;
					end else if (addr == smf_pkg::ADDR_MODE
						& reqMode == smf_pkg::MODE_NORMAL) begin
						next_s.mode = smf_pkg::MODE_NORMAL; // [R15]
					end else if (addr == smf_pkg::ADDR_MODE
						& reqMode == smf_pkg::MODE_SLEEP) begin
						next_s.cmdErr = 1'b1; // [R18]
						next_s.mode = smf_pkg::MODE_RESTART;
					end else begin
						next_s.cmdErr = 1'b1; // [R15] [R16]
					end
				end else if (addr == smf_pkg::ADDR_MODE) begin
					next_s.ovRstEn = wrData[smf_pkg::BIT_OV_RST];
					next_s.failSel = wrData[smf_pkg::BIT_FAIL_SEL];
					next_s.foTest = wrData[smf_pkg::BIT_FO_TEST]; // [R14]
					next_s.measSel = wrData[smf_pkg::BIT_MEAS];
					if (wrData[smf_pkg::BIT_SOFT_RST]) begin
						next_s.mode = smf_pkg::MODE_INIT;
					end else if (s.mode == smf_pkg::MODE_NORMAL
						& (reqMode == smf_pkg::MODE_STOP | reqMode == smf_pkg::MODE_SLEEP)) begin
						next_s.mode = reqMode; // [R24]
					end
				end else if (addr == smf_pkg::ADDR_SUPPLY) begin
					next_s.supply = wrData[5:0];
				end else if (addr == smf_pkg::ADDR_WAKE_EN) begin
					next_s.wakeEn = wrData[2:0];
				end
			end
		end
		// ----------------------------------------
		// supply and wake events; hardware set wins over a clear
		// ----------------------------------------
		if (s.s2[1] & ~(s.powerUp & s.s2[0])) begin
			next_s.uvFlag = 1'b1; // [R10]
		end
		if (s.s2[1] & ~s.powerUp
			& (s.mode == smf_pkg::MODE_NORMAL | s.mode == smf_pkg::MODE_STOP)) begin
			next_s.mode = smf_pkg::MODE_RESTART;
		end
		if (s.mode != smf_pkg::MODE_INIT & s.mode != smf_pkg::MODE_RESTART
			& ~s.powerUp) begin
			wkNew = |(wkSrc & ~s.wkFirst) | (s.s2[7] & ~s.wkSecond);
			next_s.wkFirst = next_s.wkFirst | wkSrc; // [R08]
			next_s.wkSecond = next_s.wkSecond | s.s2[7];
			if ((s.mode == smf_pkg::MODE_SLEEP | s.mode == smf_pkg::MODE_FAILSAFE)
				& ((|wkSrc) | s.s2[7])) begin
				next_s.mode = smf_pkg::MODE_RESTART;
			end
		end
		if (ovEdge & ~s.powerUp) begin
			next_s.ovFlag = 1'b1; // [R03]
			if (s.ovRstEn & active) begin
				next_s.failLatched = 1'b1; // [R04]
				next_s.mode = s.pin_sensed_config ? smf_pkg::MODE_RESTART : smf_pkg::MODE_FAILSAFE;
			end
		end
		// watchdog failure, including a missed open window in init
		if (wdFail & active) begin
			cntUp = (s.wdCnt == 2'h3) ? 2'h3 : s.wdCnt + 2'h1;
			next_s.wdCnt = cntUp;
			next_s.resetOut_b = 1'b0; // [R01]
			if (s.failSel | cntUp >= 2'h2) begin
				next_s.failLatched = 1'b1; // [R01]
			end
			if (s.pin_sensed_config | (~s.failSel & cntUp == 2'h1)) begin
				next_s.mode = smf_pkg::MODE_RESTART; // [R02] [R07]
			end else begin
				next_s.mode = smf_pkg::MODE_FAILSAFE; // [R02]
			end
		end
		// ----------------------------------------
		// mode entry effects
		// ----------------------------------------
		if (next_s.mode == smf_pkg::MODE_RESTART & s.mode != smf_pkg::MODE_RESTART) begin
			next_s.rdCnt = 16'h0000;
			next_s.resetOut_b = 1'b0;
			next_s.supply[0] = 1'b0;
			next_s.supply[4] = 1'b0; // [R13]
			if (s.supply[3:2] == smf_pkg::XCVR_ON) begin
				next_s.supply[3:2] = smf_pkg::XCVR_WAKE; // [R13]
			end
		end
		if (next_s.mode == smf_pkg::MODE_INIT & s.mode != smf_pkg::MODE_INIT) begin
			next_s.supply = smf_pkg::SUPPLY_RST; // [R12]
			next_s.foTest = 1'b0;
			next_s.failLatched = 1'b0;
			next_s.wdCnt = 2'h0;
		end
		if (next_s.mode == smf_pkg::MODE_STOP & s.mode != smf_pkg::MODE_STOP
			& ((|s.wkFirst) | s.wkSecond)) begin
			next_s.intCnt = 4'(smf_pkg::INT_PULSE_CYC); // [R17]
		end
		if (wkNew & (s.mode == smf_pkg::MODE_NORMAL | s.mode == smf_pkg::MODE_STOP)) begin
			next_s.intCnt = 4'(smf_pkg::INT_PULSE_CYC); // [R11]
		end
		if (next_s.mode == smf_pkg::MODE_FAILSAFE) begin
			next_s.resetOut_b = 1'b0;
		end
		next_s.intPinOe = (next_s.intCnt != 4'h0) | next_s.powerUp; // [R21]
		next_s.failOutputs_b = ~(~next_s.powerUp & (next_s.failLatched // [R10]
			| (next_s.foTest & (next_s.mode == smf_pkg::MODE_NORMAL
			| next_s.mode == smf_pkg::MODE_STOP)))); // [R14] [R16]
	end

	always_ff @(posedge clock) begin
		if (!rst_b) begin
			s <= '0;
			s.mode <= smf_pkg::MODE_INIT;
			s.powerUp <= 1'b1;
			s.supply <= smf_pkg::SUPPLY_RST;
			s.wakeEn <= smf_pkg::WAKE_EN_RST;
			s.intPinOe <= 1'b1;
			s.failOutputs_b <= 1'b1;
		end else begin
			s <= next_s;
		end
	end

	assign rdData = s.rdData;
	assign intPinOut = s.intPinOut;
	assign intPinOe = s.intPinOe;
	assign resetOut_b = s.resetOut_b;
	assign failOutputs_b = s.failOutputs_b;
	assign secondRegOn = s.supply[0];
	assign thirdRegOn = s.supply[1];
	assign xcvrMode = s.supply[3:2];
	assign highSideOn = s.supply[4];
	assign cyclicOn = s.supply[5];
	assign mode = s.mode;

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_b);

	// ----------------------------------------
	// watchdog and overvoltage failures, stored configuration
	// ----------------------------------------
	a_wd_reset: assert property (wdFail && active |=> !resetOut_b) // [R01]
		else $error("reset output not low after watchdog failure");
	a_fail_first: assert property (wdFail && active && s.failSel |=> !failOutputs_b) // [R01]
		else $error("fail outputs not active after first failure");
	a_wd_strap: assert property ( // [R02]
		wdFail && active && s.pin_sensed_config
		|=> mode == smf_pkg::MODE_RESTART)
		else $error("strap high failure did not enter restart");
	a_ov_keep: assert property ( // [R03]
		ovEdge && !s.powerUp && !s.ovRstEn && !wdFail && !wrStb
		&& !s.s2[1] && mode != smf_pkg::MODE_SLEEP && mode != smf_pkg::MODE_FAILSAFE
		&& mode != smf_pkg::MODE_RESTART && mode != smf_pkg::MODE_INIT
		|=> s.ovFlag && failOutputs_b == $past(failOutputs_b) && mode == $past(mode))
		else $error("overvoltage without enable changed mode or fail state");
	a_ov_reset: assert property ( // [R04]
		ovEdge && s.ovRstEn && active && !wdFail
		|=> s.ovFlag && !failOutputs_b
		&& mode == ($past(s.pin_sensed_config) ? smf_pkg::MODE_RESTART : smf_pkg::MODE_FAILSAFE))
		else $error("overvoltage reset handling wrong");
	a_cfg_hold: assert property (!s.powerUp |=> $stable(s.pin_sensed_config)) // [R05]
		else $error("stored configuration changed");

	// ----------------------------------------
	// init and power-up
	// ----------------------------------------
	a_init_exit: assert property ( // [R06]
		mode == smf_pkg::MODE_INIT && active && rdStb && !wdFail && !ovEdge
		|=> mode == smf_pkg::MODE_NORMAL)
		else $error("init did not leave on command");
	a_init_nowake: assert property ( // [R08]
		mode == smf_pkg::MODE_INIT && !wrStb
		|=> $stable(s.wkFirst) && $stable(s.wkSecond))
		else $error("wake flag set during init");
	a_pwr_reset: assert property (s.powerUp && s.s2[1] |=> !resetOut_b [*2]) // [R10]
		else $error("reset output released under undervoltage");
	a_pwr_fail: assert property (s.powerUp |=> failOutputs_b) // [R10]
		else $error("fail outputs active during power-up");

	// ----------------------------------------
	// stop mode, wake and test bit
	// ----------------------------------------
	a_stop_freeze: assert property ( // [R15] [R16]
		mode == smf_pkg::MODE_STOP && active && wrStb && addr == smf_pkg::ADDR_SUPPLY
		&& !wdFail && !ovEdge && !s.s2[1]
		|=> s.cmdErr && $stable(s.supply))
		else $error("stop mode accepted a setting write");
	a_stop_sleep: assert property ( // [R18]
		mode == smf_pkg::MODE_STOP && active && wrStb && !wdFail && !ovEdge
		&& addr == smf_pkg::ADDR_MODE && !wrData[smf_pkg::BIT_SOFT_RST]
		&& reqMode == smf_pkg::MODE_SLEEP
		|=> s.cmdErr && mode == smf_pkg::MODE_RESTART && !resetOut_b)
		else $error("stop to sleep not refused");
	a_wake_int: assert property ( // [R11]
		wkNew && (mode == smf_pkg::MODE_NORMAL || mode == smf_pkg::MODE_STOP)
		|=> intPinOe)
		else $error("wake in normal or stop raised no interrupt");
	a_stop_entry: assert property ( // [R17]
		mode != smf_pkg::MODE_STOP && ((|s.wkFirst) || s.wkSecond)
		##1 mode == smf_pkg::MODE_STOP |-> intPinOe)
		else $error("stop entry with wake flags raised no interrupt");
	a_fo_test: assert property ( // [R14]
		mode == smf_pkg::MODE_NORMAL && active && wrStb && addr == smf_pkg::ADDR_MODE
		&& reqMode == smf_pkg::MODE_NORMAL && !wrData[smf_pkg::BIT_SOFT_RST]
		&& !s.failLatched && !wdFail && !ovEdge && !s.s2[1]
		|=> failOutputs_b != $past(wrData[smf_pkg::BIT_FO_TEST]))
		else $error("test bit did not drive the fail outputs");

	c_restart_done: cover property (mode == smf_pkg::MODE_RESTART
		##1 mode == smf_pkg::MODE_NORMAL);
	c_stop_int: cover property (mode == smf_pkg::MODE_STOP && intPinOe);
	c_failsafe: cover property (wdFail && active && !s.pin_sensed_config);
	c_ov_reset: cover property (ovEdge && s.ovRstEn && active);
	c_meas_mask: cover property (s.measSel && (|s.s2[5:4]) && (|s.wakeEn[1:0]));
endmodule : smf_controller

// [verification/smf_pin_model.sv]
/* interrupt pin as seen from outside the controller.
   assumes a weak pull-down while reset output is low, a strong one otherwise. */
`timescale 1ns/100ps
module smf_pin_model (
	input wire logic clock,
	input wire logic pullUp,
	input wire logic intPinOut,
	input wire logic intPinOe,
	input wire logic resetOut_b,
	output logic intPin
);
	// ---------------------------------------------
	// open-drain line
	// ---------------------------------------------
	logic floatLvl = 1'b0;
	// a floating line keeps no value, so it flips every cycle
	always @(posedge clock) begin
		floatLvl <= ~floatLvl;
	end
	// strap sensing pull-down is weak, so an external pull-up wins over it
	assign intPin = (intPinOe && (resetOut_b || !pullUp)) ? intPinOut
		: (pullUp ? 1'b1 : floatLvl);
endmodule : smf_pin_model

// [verification/testbench.sv]
/* self-checking bench for smf_controller: power-up, failures, wake, stop.
   assumes smf_pin_model on the interrupt line and shortened delays. */
`timescale 1ns/100ps
module testbench;
	localparam logic [7:0] FO = 8'h01 << smf_pkg::BIT_FO_TEST;
	localparam logic [7:0] OVR = 8'h01 << smf_pkg::BIT_OV_RST;
	localparam logic [7:0] SEL = 8'h01 << smf_pkg::BIT_FAIL_SEL;
	localparam logic [7:0] MEAS = 8'h01 << smf_pkg::BIT_MEAS;
	localparam int RDC = 8;
	logic clock = 1'b0;
	logic rst_b = 1'b0;
	logic [3:0] addr = 4'h0;
	logic [7:0] wrData = 8'h00;
	logic wrStb = 1'b0;
	logic rdStb = 1'b0;
	logic wdFail = 1'b0;
	logic vsLow = 1'b1;
	logic mainUnder = 1'b1;
	logic mainOver = 1'b0;
	logic [2:0] wakeInputs = 3'h0;
	logic busWake = 1'b0;
	logic pullUp = 1'b1;
	logic [7:0] rdData;
	logic intPin, intPinOut, intPinOe, resetOut_b, failOutputs_b;
	logic secondRegOn, thirdRegOn, highSideOn, cyclicOn, seen;
	logic [1:0] xcvrMode;
	smf_pkg::smf_mode_t mode;
	logic [7:0] d;
	int miscompares = 0;
	int n_compared = 0;
	int cycles = 0;
	int seed = 23255;

	always #4 clock = ~clock;

	smf_controller #(.RESET_DELAY_CYC(RDC), .CFG_FILTER_CYC(4)) uut (.clock(clock),
		.rst_b(rst_b), .addr(addr), .wrData(wrData), .wrStb(wrStb), .rdStb(rdStb),
		.rdData(rdData), .wdFail(wdFail), .vsLow(vsLow), .mainUnder(mainUnder),
		.mainOver(mainOver), .wakeInputs(wakeInputs), .busWake(busWake),
		.intPinIn(intPin), .intPinOut(intPinOut), .intPinOe(intPinOe),
		.resetOut_b(resetOut_b), .failOutputs_b(failOutputs_b),
		.secondRegOn(secondRegOn), .thirdRegOn(thirdRegOn), .xcvrMode(xcvrMode),
		.highSideOn(highSideOn), .cyclicOn(cyclicOn), .mode(mode));
	smf_pin_model pins (.clock(clock), .pullUp(pullUp), .intPinOut(intPinOut),
		.intPinOe(intPinOe), .resetOut_b(resetOut_b), .intPin(intPin));

	// ---------------------------------------------
	// helpers
	// ---------------------------------------------
	function automatic logic [7:0] outs();
		return {2'h0, cyclicOn, highSideOn, xcvrMode, thirdRegOn, secondRegOn};
	endfunction : outs
	function automatic logic [2:0] expFail(input logic strap, input logic sel, input int n);
		if (strap || (!sel && n == 1)) begin
			return smf_pkg::MODE_RESTART;
		end
		return smf_pkg::MODE_FAILSAFE;
	endfunction : expFail
	function automatic logic expFoOff(input logic sel, input int n);
		return !(sel || n >= 2);
	endfunction : expFoOff
	task automatic chk(input logic [15:0] got, input logic [15:0] want);
		n_compared++;
		if (got !== want) begin
			miscompares++;
			$display("[ERR] %0t got %h expected %h", $time, got, want);
		end
	endtask : chk
	task automatic wr(input logic [3:0] a, input logic [7:0] v);
		@(posedge clock);
		addr <= a;
		wrData <= v;
		wrStb <= 1'b1;
		@(posedge clock);
		wrStb <= 1'b0;
		#1;
	endtask : wr
	task automatic rd(input logic [3:0] a);
		@(posedge clock);
		addr <= a;
		rdStb <= 1'b1;
		@(posedge clock);
		rdStb <= 1'b0;
		#1;
		d = rdData;
	endtask : rd
	task automatic waitRst(input logic v);
		for (int i = 0; i < 400 && resetOut_b !== v; i++) @(posedge clock);
		#1;
		chk(resetOut_b, v);
	endtask : waitRst
	task automatic seeInt(input logic want);
		seen = 1'b0;
		repeat (24) begin
			@(posedge clock);
			#1;
			seen |= intPinOe;
		end
		chk(seen, want);
	endtask : seeInt
	task automatic failPulse();
		@(posedge clock);
		wdFail <= 1'b1;
		@(posedge clock);
		wdFail <= 1'b0;
		@(posedge clock);
		#1;
	endtask : failPulse
	task automatic powerUp(input logic pu);
		rst_b <= 1'b0;
		pullUp <= pu;
		mainUnder <= 1'b1;
		vsLow <= 1'b1;
		wakeInputs <= 3'h0;
		repeat (2) @(posedge clock);
		rst_b <= 1'b1;
		repeat (12) @(posedge clock);
		#1;
		chk({resetOut_b, failOutputs_b}, 8'h01);
		@(posedge clock);
		mainUnder <= 1'b0;
		vsLow <= 1'b0;
		repeat (RDC - 1) @(posedge clock);
		#1;
		chk(resetOut_b, 1'b0);
		waitRst(1'b1);
		@(posedge clock);
		busWake <= 1'b1;
		seeInt(1'b0);
		@(posedge clock);
		busWake <= 1'b0;
		repeat (4) @(posedge clock);
		rd(smf_pkg::ADDR_WAKE_SECOND);
		chk(d, 8'h00);
		chk(mode, smf_pkg::MODE_NORMAL);
		rd(smf_pkg::ADDR_STATUS);
		chk(d & 8'h0a, {4'h0, pu, 3'h0});
		chk({outs(), failOutputs_b}, 9'h001);
	endtask : powerUp
	task close_out();
		$display("compared %0d mismatches %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : close_out

	always @(posedge clock) begin
		cycles++;
		if (cycles == 20000) begin
			miscompares++;
			close_out();
		end
	end

	// ---------------------------------------------
	// scenarios
	// ---------------------------------------------
	initial begin
		powerUp(1'b1);
		wr(smf_pkg::ADDR_MODE, FO);
		chk(failOutputs_b, 1'b0);
		wr(smf_pkg::ADDR_MODE, 8'h00);
		chk(failOutputs_b, 1'b1);
		wr(smf_pkg::ADDR_SUPPLY, 8'h3b);
		wr(smf_pkg::ADDR_WAKE_EN, 8'h01);
		@(posedge clock);
		wakeInputs <= 3'h1;
		seeInt(1'b1);
		chk(mode, smf_pkg::MODE_NORMAL);
		rd(smf_pkg::ADDR_WAKE_LEVEL);
		chk(d, 8'h01);
		// flag left set on purpose so stop entry raises the pin
		wr(smf_pkg::ADDR_MODE, {5'h00, smf_pkg::MODE_STOP});
		seeInt(1'b1);
		chk(mode, smf_pkg::MODE_STOP);
		repeat (4) begin
			wr(smf_pkg::ADDR_SUPPLY, 8'($random(seed)));
			chk(outs(), 8'h3b);
			rd(smf_pkg::ADDR_STATUS);
			chk(d[2], 1'b1);
			wr(smf_pkg::ADDR_STATUS, 8'h04);
		end
		rd(4'hf);
		chk(d, 8'h00);
		@(posedge clock);
		wakeInputs <= 3'h0;
		repeat (4) @(posedge clock);
		// clear only once the input is low, else the set wins again
		wr(smf_pkg::ADDR_WAKE_FIRST, 8'h07);
		wakeInputs <= 3'h1;
		seeInt(1'b1);
		chk(mode, smf_pkg::MODE_STOP);
		wr(smf_pkg::ADDR_MODE, {5'h00, smf_pkg::MODE_SLEEP});
		chk({resetOut_b, mode}, {1'b0, smf_pkg::MODE_RESTART});
		waitRst(1'b1);
		chk({outs() & 8'h1e, failOutputs_b}, 9'h00d);
		rd(smf_pkg::ADDR_MODE);
		chk(d[2:0], smf_pkg::MODE_NORMAL);
		rd(smf_pkg::ADDR_STATUS);
		chk(d[2], 1'b1);
		wr(smf_pkg::ADDR_STATUS, 8'h3f);
		@(posedge clock);
		mainOver <= 1'b1;
		repeat (6) @(posedge clock);
		#1;
		chk({mode, failOutputs_b}, {smf_pkg::MODE_NORMAL, 1'b1});
		rd(smf_pkg::ADDR_STATUS);
		chk(d[0], 1'b1);
		@(posedge clock);
		mainOver <= 1'b0;
		wr(smf_pkg::ADDR_MODE, SEL);
		failPulse();
		chk({resetOut_b, failOutputs_b}, {1'b0, expFoOff(1'b1, 1)});
		chk(mode, expFail(1'b1, 1'b1, 1));
		waitRst(1'b1);
		chk(failOutputs_b, 1'b0);
		powerUp(1'b1);
		wr(smf_pkg::ADDR_MODE, OVR);
		@(posedge clock);
		mainOver <= 1'b1;
		pullUp <= 1'b0;
		waitRst(1'b0);
		chk({mode, failOutputs_b}, {smf_pkg::MODE_RESTART, 1'b0});
		@(posedge clock);
		mainOver <= 1'b0;
		waitRst(1'b1);
		rd(smf_pkg::ADDR_STATUS);
		chk(d & 8'h09, 8'h09);
		powerUp(1'b0);
		failPulse();
		chk({resetOut_b, failOutputs_b}, {1'b0, expFoOff(1'b0, 1)});
		chk(mode, expFail(1'b0, 1'b0, 1));
		waitRst(1'b1);
		failPulse();
		chk(failOutputs_b, expFoOff(1'b0, 2));
		chk(mode, expFail(1'b0, 1'b0, 2));
		powerUp(1'b0);
		wr(smf_pkg::ADDR_MODE, MEAS);
		wr(smf_pkg::ADDR_WAKE_EN, 8'h07);
		@(posedge clock);
		wakeInputs <= 3'h3;
		seeInt(1'b0);
		rd(smf_pkg::ADDR_WAKE_FIRST);
		chk(d, 8'h00);
		@(posedge clock);
		wakeInputs <= 3'h7;
		seeInt(1'b1);
		rd(smf_pkg::ADDR_WAKE_FIRST);
		chk(d, 8'h04);
		close_out();
	end
endmodule : testbench
